// File: common/pmf_defs.svh
// constants for the pulse programming state machine
//
// Notes on behaviour
// - pin splits into low, mid, high symbols
// - mid to low edge advances selection
// - power up: initial state, intact bits cleared
// - initial ignores low, high enters mode selection
// - low count picks trial, burn, lock mode
// - mode counter wraps past last mode
// - high needs nonzero mode to reach register selection
// - low count picks one of seven registers
// - register widths 2,9,2,8,5,2,1 bits
// - high enters bitfield selection
// - trial mode: low adds one immediately
// - high returns to mode selection, burning while the pin stays high
// - lock fuse refuses all further programming
// - entering bitfield selection clears intact bits
// - high rise changes state, drop below steps
// - lock flag is register 0 bitfield 1
`ifndef PMF_DEFS_SVH
`define PMF_DEFS_SVH

// clock rate and level filter
`define PMF_CLK_KHZ          10000
`define PMF_FILTER_NS        2000
`define PMF_FILTER_CYC       ((`PMF_FILTER_NS * `PMF_CLK_KHZ + 999999) / 1000000)

// programmer side minimum times, ns
`define PMF_STATE_CHANGE_NS  20000
`define PMF_BURN_PULSE_NS    100000
`define PMF_STEP_PULSE_NS    6000
`define PMF_POST_HIGH_NS     15000
`define PMF_STEP_GAP_NS      6000

// trim register field widths
`define PMF_W_QRANGE         2
`define PMF_W_QFINE          9
`define PMF_W_GRANGE         2
`define PMF_W_GFINE          8
`define PMF_W_DRIFT          5
`define PMF_W_LIMIT          2
`define PMF_W_SIGN           1

// field offsets in the packed trim word
`define PMF_OFF_QRANGE       0
`define PMF_OFF_QFINE        2
`define PMF_OFF_GRANGE       11
`define PMF_OFF_GFINE        13
`define PMF_OFF_DRIFT        21
`define PMF_OFF_LIMIT        26
`define PMF_OFF_SIGN         28
`define PMF_TRIM_BITS        29
`define PMF_NUM_REGS         7
`define PMF_LAST_REG         3'h6
`define PMF_CODE_BITS        9

// mode codes and lock location
`define PMF_MODE_NONE        2'h0
`define PMF_MODE_TRIAL       2'h1
`define PMF_MODE_BURN        2'h2
`define PMF_MODE_LOCK        2'h3
`define PMF_LOCK_REG         3'h0
`define PMF_LOCK_CODE        9'h001

`endif

// File: common/pmf_pkg.sv
// types for the pulse programming state machine
`include "pmf_defs.svh"
package pmf_pkg;

	typedef enum logic [1:0] {SYM_LOW, SYM_MID, SYM_HIGH} pmf_sym_t;

	typedef enum logic [1:0] {ST_INIT, ST_MODE, ST_REG, ST_BIT} pmf_state_t;

	typedef struct packed {
		logic [`PMF_W_SIGN-1:0]   sign;
		logic [`PMF_W_LIMIT-1:0]  limit;
		logic [`PMF_W_DRIFT-1:0]  drift;
		logic [`PMF_W_GFINE-1:0]  gain_fine;
		logic [`PMF_W_GRANGE-1:0] gain_range;
		logic [`PMF_W_QFINE-1:0]  q_fine;
		logic [`PMF_W_QRANGE-1:0] q_range;
	} pmf_trim_t;

	localparam int unsigned PMF_OFF [`PMF_NUM_REGS] = '{`PMF_OFF_QRANGE,
		`PMF_OFF_QFINE, `PMF_OFF_GRANGE, `PMF_OFF_GFINE, `PMF_OFF_DRIFT,
		`PMF_OFF_LIMIT, `PMF_OFF_SIGN};
	localparam int unsigned PMF_WID [`PMF_NUM_REGS] = '{`PMF_W_QRANGE,
		`PMF_W_QFINE, `PMF_W_GRANGE, `PMF_W_GFINE, `PMF_W_DRIFT,
		`PMF_W_LIMIT, `PMF_W_SIGN};

endpackage

// File: rtl/pmf_level_qual.sv
// pin level classifier with persistence filter and edge events
`timescale 1ns/100ps
`default_nettype none
`include "pmf_defs.svh"
module pmf_level_qual
	import pmf_pkg::*;
#(
	parameter int unsigned FILTER_CYC = `PMF_FILTER_CYC
) (
	input  wire logic mclk,
	input  wire logic rst,
	input  wire logic above_low,
	input  wire logic above_high,
	output logic      low_evt,
	output logic      high_evt,
	output pmf_sym_t  level
);
	localparam int CW = $clog2(FILTER_CYC + 1);

	typedef struct packed {
		pmf_sym_t        cand;
		logic [CW-1:0]   cnt;
		pmf_sym_t        level;
		logic            low_evt;
		logic            high_evt;
	} pmf_qual_st_t;

	pmf_qual_st_t st_ff, nxt_st;
	pmf_sym_t     raw;

	always_comb begin
		raw = above_high ? SYM_HIGH : (above_low ? SYM_MID : SYM_LOW);
		nxt_st = st_ff;
		nxt_st.low_evt = 1'b0;
		nxt_st.high_evt = 1'b0;
		if (raw != st_ff.cand) begin
			nxt_st.cand = raw;
			nxt_st.cnt = '0;
		end else if (st_ff.cnt < CW'(FILTER_CYC)) begin
			nxt_st.cnt = st_ff.cnt + 1'b1;
		end else if (st_ff.level != raw) begin
			// a level counts only after persisting the filter time
			nxt_st.level = raw;
			nxt_st.high_evt = (raw == SYM_HIGH);
			nxt_st.low_evt = (raw == SYM_LOW);
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st_ff <= '{SYM_MID, '0, SYM_MID, 1'b0, 1'b0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign low_evt = st_ff.low_evt;
	assign high_evt = st_ff.high_evt;
	assign level = st_ff.level;
endmodule
`default_nettype wire

// File: rtl/pmf_trim_bank.sv
// seven trial trim registers merged with fuse state
`timescale 1ns/100ps
`default_nettype none
`include "pmf_defs.svh"
module pmf_trim_bank
	import pmf_pkg::*;
(
	input  wire logic                     mclk,
	input  wire logic                     rst,
	input  wire logic [`PMF_NUM_REGS-1:0] clr_sel,
	input  wire logic [`PMF_NUM_REGS-1:0] inc_sel,
	input  wire pmf_trim_t                fuse_blown,
	output pmf_trim_t                     trim
);
	typedef struct packed {
		logic [`PMF_TRIM_BITS-1:0] trial;
		logic [`PMF_TRIM_BITS-1:0] value;
	} pmf_bank_st_t;

	pmf_bank_st_t              st_ff, nxt_st;
	logic [`PMF_TRIM_BITS-1:0] seg_nxt;
	logic [`PMF_TRIM_BITS-1:0] blown;

	assign blown = fuse_blown;

	for (genvar g = 0; g < `PMF_NUM_REGS; g++) begin : g_reg
		localparam int unsigned O = PMF_OFF[g];
		localparam int unsigned W = PMF_WID[g];
		logic [W-1:0] cur;
		assign cur = st_ff.trial[O +: W] | blown[O +: W];
		// clearing leaves blown bits at one through the merge below
		assign seg_nxt[O +: W] = clr_sel[g] ? '0 :
			(inc_sel[g] ? cur + 1'b1 : st_ff.trial[O +: W]);
	end

	always_comb begin
		nxt_st.trial = seg_nxt;
		nxt_st.value = seg_nxt | blown;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign trim = st_ff.value;
endmodule
`default_nettype wire

// File: rtl/pmf_prog_fsm.sv
// one pin pulse programming state machine, top level
`timescale 1ns/100ps
`default_nettype none
`include "pmf_defs.svh"
module pmf_prog_fsm
	import pmf_pkg::*;
#(
	parameter int unsigned FILTER_CYC = `PMF_FILTER_CYC
) (
	input  wire logic      mclk,
	input  wire logic      rst,
	input  wire logic      above_low,
	input  wire logic      above_high,
	input  wire pmf_trim_t fuse_blown,
	input  wire logic      lock_fuse_blown,
	output pmf_trim_t      trim,
	output pmf_trim_t      burn_mask,
	output logic           lock_burn,
	output logic           locked,
	output pmf_state_t     prog_state,
	output logic [1:0]     mode
);
	typedef struct packed {
		pmf_state_t               state;
		logic [1:0]               mode;
		logic [2:0]               reg_sel;
		logic [`PMF_CODE_BITS-1:0] code;
		logic [`PMF_NUM_REGS-1:0] clr_sel;
		logic [`PMF_NUM_REGS-1:0] inc_sel;
		logic [`PMF_TRIM_BITS-1:0] burn;
		logic                     lock_burn;
		logic                     locked;
	} pmf_top_st_t;

	pmf_top_st_t st_ff, nxt_st;
	logic        low_evt;
	logic        high_evt;
	pmf_sym_t    level;
	logic [`PMF_TRIM_BITS-1:0] field_mask;
	logic [`PMF_TRIM_BITS-1:0] code_at;

	pmf_level_qual #(
		.FILTER_CYC (FILTER_CYC)
	) u_qual (
		.mclk       (mclk),
		.rst        (rst),
		.above_low  (above_low),
		.above_high (above_high),
		.low_evt    (low_evt),
		.high_evt   (high_evt),
		.level      (level)
	);

	pmf_trim_bank u_bank (
		.mclk       (mclk),
		.rst        (rst),
		.clr_sel    (st_ff.clr_sel),
		.inc_sel    (st_ff.inc_sel),
		.fuse_blown (fuse_blown),
		.trim       (trim)
	);

	// selected field mask and code placed at its offset
	always_comb begin
		field_mask = '0;
		code_at = '0;
		for (int i = 0; i < `PMF_NUM_REGS; i++) begin
			if (st_ff.reg_sel == 3'(i)) begin
				field_mask = ((`PMF_TRIM_BITS'(1) << PMF_WID[i]) - 1'b1)
					<< PMF_OFF[i];
				code_at = `PMF_TRIM_BITS'(st_ff.code) << PMF_OFF[i];
			end
		end
	end

	always_comb begin
		nxt_st = st_ff;
		nxt_st.clr_sel = '0;
		nxt_st.inc_sel = '0;
		nxt_st.locked = lock_fuse_blown;
		// burn drive lasts only as long as the pin stays high
		if (level != SYM_HIGH) begin
			nxt_st.burn = '0;
			nxt_st.lock_burn = 1'b0;
		end
		case (st_ff.state)
			ST_INIT: begin
				if (high_evt) begin
					nxt_st.state = ST_MODE;
					nxt_st.mode = `PMF_MODE_NONE;
				end
			end
			ST_MODE: begin
				if (low_evt) begin
					nxt_st.mode = st_ff.mode + 1'b1;
				end else if (high_evt && st_ff.mode != `PMF_MODE_NONE) begin
					nxt_st.state = ST_REG;
					nxt_st.reg_sel = '0;
				end
			end
			ST_REG: begin
				if (low_evt) begin
					nxt_st.reg_sel = (st_ff.reg_sel == `PMF_LAST_REG) ? '0 :
						st_ff.reg_sel + 1'b1;
				end else if (high_evt) begin
					nxt_st.state = ST_BIT;
					nxt_st.code = '0;
					// a locked device refuses every change
					if (!st_ff.locked) begin
						nxt_st.clr_sel[st_ff.reg_sel] = 1'b1;
					end
				end
			end
			ST_BIT: begin
				if (low_evt) begin
					nxt_st.code = st_ff.code + 1'b1;
					if (st_ff.mode == `PMF_MODE_TRIAL && !st_ff.locked) begin
						nxt_st.inc_sel[st_ff.reg_sel] = 1'b1;
					end
				end else if (high_evt) begin
					nxt_st.state = ST_MODE;
					nxt_st.mode = `PMF_MODE_NONE;
					if (!st_ff.locked) begin
						if (st_ff.mode == `PMF_MODE_BURN) begin
							nxt_st.burn = code_at & field_mask;
						end
						if (st_ff.mode == `PMF_MODE_LOCK &&
							st_ff.reg_sel == `PMF_LOCK_REG &&
							st_ff.code == `PMF_LOCK_CODE) begin
							nxt_st.lock_burn = 1'b1;
						end
					end
				end
			end
			default: begin
				nxt_st.state = ST_INIT;
			end
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st_ff <= '{ST_INIT, `PMF_MODE_NONE, 3'h0, '0, '0, '0, '0,
				1'b0, 1'b0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign burn_mask = st_ff.burn;
	assign lock_burn = st_ff.lock_burn;
	assign locked = st_ff.locked;
	assign prog_state = st_ff.state;
	assign mode = st_ff.mode;
endmodule
`default_nettype wire

// File: bench/pmf_prog_fsm_asserts.sv
// port assertions for the pulse programming state machine
`timescale 1ns/100ps
`default_nettype none
`include "pmf_defs.svh"
module pmf_prog_fsm_asserts
	import pmf_pkg::*;
#(
	parameter int unsigned FILTER_CYC = `PMF_FILTER_CYC
) (
	input wire logic       mclk,
	input wire logic       rst,
	input wire logic       above_low,
	input wire logic       above_high,
	input wire pmf_trim_t  fuse_blown,
	input wire logic       lock_fuse_blown,
	input wire pmf_trim_t  trim,
	input wire pmf_trim_t  burn_mask,
	input wire logic       lock_burn,
	input wire logic       locked,
	input wire pmf_state_t prog_state,
	input wire logic [1:0] mode
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	// eight mid cycles outlast filter plus register; needs FILTER_CYC <= 5
	sequence s_mid_run;
		(above_low && !above_high) [*8];
	endsequence
	sequence s_mode_hold;
		prog_state == ST_MODE ##1 prog_state == ST_MODE;
	endsequence
	AST_STATE_WALK: assert property ($changed(prog_state) |->
		prog_state == (($past(prog_state) == ST_BIT) ? ST_MODE :
		pmf_state_t'($past(prog_state) + 2'h1)))
		else $error("illegal state step");
	AST_MODE_ZERO_HOLDS: assert property (
		prog_state == ST_MODE && mode == 2'h0 |=> prog_state != ST_REG)
		else $error("left mode selection with no mode");
	AST_MODE_STEP: assert property (
		s_mode_hold ##0 $changed(mode) |-> mode == $past(mode) + 2'h1)
		else $error("mode count did not step by one");
	AST_MODE_FRESH: assert property (
		prog_state == ST_MODE && $past(prog_state) == ST_BIT |->
		mode == 2'h0)
		else $error("mode not cleared on return");
	AST_LOCK_BLOCKS_BURN: assert property (
		locked |-> burn_mask == '0 && !lock_burn)
		else $error("burn drive while locked");
	AST_BURN_ON_EXIT: assert property ($rose(|burn_mask) |->
		prog_state == ST_MODE && $past(prog_state) == ST_BIT && above_high)
		else $error("burn drive outside bitfield exit");
	AST_LOCK_ON_EXIT: assert property ($rose(lock_burn) |->
		prog_state == ST_MODE && $past(prog_state) == ST_BIT)
		else $error("lock drive outside bitfield exit");
	AST_BLOWN_READS_ONE: assert property (
		!$past(rst) && !$past(rst, 2) |->
		(trim | $past(fuse_blown, 2)) == trim)
		else $error("blown bit reads zero");
	AST_MID_NEUTRAL: assert property (s_mid_run |=>
		$stable(prog_state) && $stable(mode))
		else $error("state moved on a steady mid level");
endmodule
bind pmf_prog_fsm pmf_prog_fsm_asserts #(.FILTER_CYC(FILTER_CYC)) u_chk (
	.mclk(mclk), .rst(rst), .above_low(above_low),
	.above_high(above_high), .fuse_blown(fuse_blown),
	.lock_fuse_blown(lock_fuse_blown), .trim(trim),
	.burn_mask(burn_mask), .lock_burn(lock_burn), .locked(locked),
	.prog_state(prog_state), .mode(mode));
`default_nettype wire

// File: bench/pmf_programmer.sv
// pulse programmer on the pin plus the fuse array it burns
`timescale 1ns/100ps
`default_nettype none
module pmf_programmer
	import pmf_pkg::*;
(
	input  wire logic      mclk,
	input  wire pmf_sym_t  sym,
	input  wire pmf_trim_t burn_mask,
	input  wire logic      lock_burn,
	output logic           above_low,
	output logic           above_high,
	output pmf_trim_t      fuse_blown,
	output logic           lock_fuse_blown
);
	pmf_trim_t burn_q;
	logic      lock_q;
	assign above_high = (sym == SYM_HIGH);
	assign above_low  = (sym != SYM_LOW);
	initial begin
		burn_q = '0;
		lock_q = 1'b0;
		fuse_blown = '0;
		lock_fuse_blown = 1'b0;
	end
	// fuses open when the drive ends and never heal
	always @(posedge mclk) begin
		burn_q <= burn_mask;
		lock_q <= lock_burn;
		fuse_blown <= fuse_blown | (burn_q & ~burn_mask);
		lock_fuse_blown <= lock_fuse_blown | (lock_q & !lock_burn);
	end
endmodule
`default_nettype wire

// File: bench/testbench.sv
// self-checking bench for the pulse programming state machine
`timescale 1ns/100ps
`default_nettype none
`include "pmf_defs.svh"
module testbench
	import pmf_pkg::*;
;
	localparam int unsigned HP = `PMF_STATE_CHANGE_NS;
	localparam int unsigned BP = `PMF_BURN_PULSE_NS;
	logic        mclk;
	logic        rst;
	pmf_sym_t    sym;
	logic        above_low, above_high, lock_burn, locked, lock_fuse_blown;
	pmf_trim_t   fuse_blown, trim, burn_mask;
	pmf_state_t  prog_state;
	logic [1:0]  mode;
	int          n_fail = 0;
	int          total_checks = 0;
	int unsigned cyc = 0;
	// mode pulses, register pulses, steps, field, expected value
	int unsigned rows [7][5] = '{
		'{1, 0, 5, 0, 1}, '{5, 1, 5, 1, 5}, '{1, 9, 7, 2, 3},
		'{1, 3, 9, 3, 9}, '{1, 4, 33, 4, 1}, '{1, 5, 3, 5, 3},
		'{1, 6, 3, 6, 1}};
	pmf_programmer prg (.mclk(mclk), .sym(sym), .burn_mask(burn_mask),
		.lock_burn(lock_burn), .above_low(above_low),
		.above_high(above_high), .fuse_blown(fuse_blown),
		.lock_fuse_blown(lock_fuse_blown));
	pmf_prog_fsm #(.FILTER_CYC(3)) uut (.mclk(mclk), .rst(rst),
		.above_low(above_low), .above_high(above_high),
		.fuse_blown(fuse_blown), .lock_fuse_blown(lock_fuse_blown),
		.trim(trim), .burn_mask(burn_mask), .lock_burn(lock_burn),
		.locked(locked), .prog_state(prog_state), .mode(mode));
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// whole run needs about 32k cycles
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			n_fail++;
			test_done();
		end
	end
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	function automatic logic [31:0] fld(pmf_trim_t t, int unsigned f);
		return (32'(t) >> PMF_OFF[f]) & ((32'h1 << PMF_WID[f]) - 32'h1);
	endfunction
	task automatic drv(pmf_sym_t s, int unsigned ns);
		@(posedge mclk);
		#5 sym = s;
		repeat (ns / 100) @(posedge mclk);
	endtask
	task automatic hi(int unsigned ns);
		drv(SYM_HIGH, ns);
		drv(SYM_MID, `PMF_POST_HIGH_NS);
	endtask
	task automatic lo(int unsigned n);
		repeat (n) begin
			drv(SYM_LOW, `PMF_STEP_PULSE_NS);
			drv(SYM_MID, `PMF_STEP_GAP_NS);
		end
	endtask
	// from mode selection: mode, register, steps, leave
	task automatic walk(int unsigned m, r, n, hp);
		lo(m);
		hi(HP);
		lo(r);
		hi(HP);
		lo(n);
		hi(hp);
	endtask
	// as walk, but stops while the leaving high pulse still stands
	task automatic arm(int unsigned m, r, n);
		lo(m);
		hi(HP);
		lo(r);
		hi(HP);
		lo(n);
		drv(SYM_HIGH, HP);
	endtask
	task automatic do_reset();
		#5 rst = 1'b1;
		repeat (5) @(posedge mclk);
		#5 rst = 1'b0;
	endtask
	initial begin
		rst = 1'b1;
		sym = SYM_MID;
		do_reset();
		hi(HP);
		for (int i = 0; i < 7; i++) begin
			walk(rows[i][0], rows[i][1], rows[i][2], HP);
			chk("field", rows[i][4], fld(trim, rows[i][3]));
			chk("state", ST_MODE, prog_state);
			chk("mode", 0, mode);
		end
		hi(HP);
		chk("state", ST_MODE, prog_state);
		arm(2, 1, 4);
		chk("burn", 32'h10, burn_mask);
		hi(BP);
		chk("fuses", 32'h10, fuse_blown);
		do_reset();
		repeat (3) @(posedge mclk);
		chk("trim", 32'h10, trim);
		lo(2);
		chk("state", ST_INIT, prog_state);
		hi(HP);
		walk(1, 1, 1, HP);
		chk("q_fine", 5, fld(trim, 1));
		arm(3, 0, 1);
		chk("lock_burn", 1, lock_burn);
		hi(BP);
		chk("locked", 1, locked);
		walk(1, 1, 2, HP);
		chk("q_fine", 5, fld(trim, 1));
		chk("state", ST_MODE, prog_state);
		arm(2, 0, 1);
		chk("burn", 0, burn_mask);
		hi(BP);
		chk("fuses", 32'h10, fuse_blown);
		test_done();
	end
endmodule
`default_nettype wire
